/* design/fsr_pkg.sv */
// constants, field positions and types for the flash status register read path
// assumes a 16-bit flash data bus, a 23-bit word address and thirty-two planes
package fsr_pkg;

  // bus geometry
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;
  localparam int PLANE_W = 5;
  localparam int PLANE_LSB = 18;

  // status byte field positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROG_FAIL = 4;
  localparam int SR_VPP_LOW = 3;
  localparam int SR_PROG_SUSP = 2;
  localparam int SR_LOCKED = 1;
  localparam int SR_PLANE = 0;

  // fill of the upper data byte while status is shown
  localparam logic [7:0] UPPER_FILL = 8'h00;

  // command codes seen on the command strobe
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // burst clock latency in clock edges
  localparam logic [1:0] BURST_LATENCY = 2'h3;

  // reset values
  localparam logic [7:0] SNAP_RESET = 8'h80;
  localparam logic [15:0] DQ_RESET = 16'h0000;

  // burst status read sequencer
  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_LAT = 2'b01,
    BST_STREAM = 2'b10
  } fsr_burst_t;

endpackage

/* design/fsr_sync.sv */
// two-flop synchroniser for a group of pins
// assumes the group is quasi-static around the edges that the core acts on
`timescale 1ns/100ps
module fsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  import fsr_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } fsr_sync_st_t;

  fsr_sync_st_t st_q;
  fsr_sync_st_t st_d;

  // first stage feeds only the second stage
  always_comb
  begin
    st_d.meta = pin_in;
    st_d.stable = st_q.meta;
  end

  // register both stages
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q.meta <= RST_VAL;
      st_q.stable <= RST_VAL;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule

/* design/fsr_lat.sv */
// burst latency counter: counts clock edges after an address latch
// assumes tick is a one-cycle pulse per rising edge of the burst clock
`timescale 1ns/100ps
module fsr_lat (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  output logic done
);
  import fsr_pkg::*;

  typedef struct packed {
    logic busy;
    logic [1:0] cnt;
    logic done;
  } fsr_lat_st_t;

  fsr_lat_st_t st_q;
  fsr_lat_st_t st_d;

  // restart on start, finish on the last latency edge
  always_comb
  begin
    st_d = st_q;
    if (start)
    begin
      st_d.busy = 1'b1;
      st_d.cnt = 2'h0;
      st_d.done = 1'b0;
    end
    else if (st_q.busy && tick)
    begin
      if (st_q.cnt == BURST_LATENCY - 2'h1)
      begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 2'h1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;

endmodule

/* design/fsr_status.sv */
// status register read path of a flash write engine: mode, sticky flags,
// snapshot on access start and burst presentation after the clock latency
// assumes flash pins arrive unsynchronised, engine and command inputs are on core_clk
`timescale 1ns/100ps
module fsr_status (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic addr_valid_n,
  input wire logic bclk,
  input wire logic [fsr_pkg::ADDR_W-1:0] addr,
  input wire logic program_voltage_low,
  output logic [fsr_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic burst_mode,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic engine_busy,
  input wire logic [fsr_pkg::PLANE_W-1:0] busy_plane,
  input wire logic op_start,
  input wire logic target_locked,
  input wire logic erase_fail_ev,
  input wire logic program_fail_ev,
  input wire logic seq_error_ev,
  input wire logic erase_suspend_ev,
  input wire logic program_suspend_ev,
  input wire logic erase_resume_ev,
  input wire logic program_resume_ev,
  output logic status_mode,
  output logic op_abort,
  output logic [fsr_pkg::STAT_W-1:0] write_engine_status_byte
);
  import fsr_pkg::*;

  localparam int SYNC_W = ADDR_W + 5;

  typedef struct packed {
    logic ce_n_p;
    logic oe_n_p;
    logic avd_n_p;
    logic bclk_p;
    logic status_mode;
    logic erase_fail;
    logic program_fail;
    logic vpp_low;
    logic locked;
    logic erase_susp;
    logic prog_susp;
    logic op_abort;
    logic [STAT_W-1:0] snap;
    fsr_burst_t bst;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
  } fsr_state_t;

  fsr_state_t st_q;
  fsr_state_t st_d;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic s_ce_n;
  logic s_oe_n;
  logic s_avd_n;
  logic s_bclk;
  logic s_vpp_low;
  logic [ADDR_W-1:0] s_addr;
  logic bclk_tick;
  logic avd_rise;
  logic access_now;
  logic access_prev;
  logic async_start;
  logic burst_start;
  logic lat_done;
  logic clear_cmd;
  logic [STAT_W-1:0] live;

  // plane number carried in a word address
  function automatic logic [PLANE_W-1:0] plane_of(input logic [ADDR_W-1:0] a);
    plane_of = a[PLANE_LSB +: PLANE_W];
  endfunction

  // status byte built from the engine state and sticky flags
  function automatic logic [STAT_W-1:0] status_of(
    input fsr_state_t s,
    input logic busy,
    input logic [PLANE_W-1:0] bplane,
    input logic [ADDR_W-1:0] a
  );
    logic [STAT_W-1:0] b;
    b = '0;
    b[SR_READY] = ~busy;
    b[SR_ERASE_SUSP] = s.erase_susp;
    b[SR_ERASE_FAIL] = s.erase_fail;
    b[SR_PROG_FAIL] = s.program_fail;
    b[SR_VPP_LOW] = s.vpp_low;
    b[SR_PROG_SUSP] = s.prog_susp;
    b[SR_LOCKED] = s.locked;
    // busy in the addressed plane reads 0, busy elsewhere reads 1
    b[SR_PLANE] = busy & (bplane != plane_of(a));
    status_of = b;
  endfunction

  // every flash pin passes two flops before use
  assign pins_raw = {ce_n, oe_n, addr_valid_n, bclk, program_voltage_low, addr};

  // burst clock resets to its idle low level so no false edge follows reset
  fsr_sync #(
    .W(SYNC_W),
    .RST_VAL({3'h7, 2'h0, {ADDR_W{1'b0}}})
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(pins_raw),
    .sync_out(pins_s)
  );

  assign {s_ce_n, s_oe_n, s_avd_n, s_bclk, s_vpp_low, s_addr} = pins_s;

  // edges and access qualifiers on the synchronised pins
  assign bclk_tick = s_bclk & ~st_q.bclk_p;
  assign avd_rise = s_avd_n & ~st_q.avd_n_p & ~s_ce_n;
  assign access_now = ~s_ce_n & ~s_oe_n;
  assign access_prev = ~st_q.ce_n_p & ~st_q.oe_n_p;
  assign async_start = access_now & ~access_prev & ~burst_mode;
  assign burst_start = avd_rise & burst_mode;
  assign clear_cmd = cmd_wr & (cmd_code == CMD_CLEAR_STATUS);
  assign live = status_of(st_q, engine_busy, busy_plane, s_addr);

  // latency counter for burst status reads
  fsr_lat u_lat (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(burst_start),
    .tick(bclk_tick),
    .done(lat_done)
  );

  // next state: mode, flags, snapshot and output drive
  always_comb
  begin
    st_d = st_q;
    st_d.ce_n_p = s_ce_n;
    st_d.oe_n_p = s_oe_n;
    st_d.avd_n_p = s_avd_n;
    st_d.bclk_p = s_bclk;
    st_d.op_abort = 1'b0;

    // status mode follows the last command written
    if (cmd_wr)
    begin
      st_d.status_mode = (cmd_code == CMD_READ_STATUS);
    end

    // sticky error flags: clear first so a same-cycle event wins
    if (clear_cmd)
    begin
      st_d.erase_fail = 1'b0;
      st_d.program_fail = 1'b0;
      st_d.vpp_low = 1'b0;
      st_d.locked = 1'b0;
    end
    if (erase_fail_ev)
    begin
      st_d.erase_fail = 1'b1;
    end
    if (program_fail_ev)
    begin
      st_d.program_fail = 1'b1;
    end
    // supply and lock are judged only when an operation is entered
    if (op_start && s_vpp_low)
    begin
      st_d.vpp_low = 1'b1;
    end
    if (op_start && target_locked)
    begin
      st_d.locked = 1'b1;
    end
    if (op_start && (target_locked || s_vpp_low))
    begin
      st_d.op_abort = 1'b1;
    end
    if (seq_error_ev)
    begin
      st_d.erase_fail = 1'b1;
      st_d.program_fail = 1'b1;
      st_d.vpp_low = 1'b1;
      st_d.locked = 1'b1;
    end

    // suspend flags: set by suspend, cleared by the matching resume
    if (erase_resume_ev)
    begin
      st_d.erase_susp = 1'b0;
    end
    if (erase_suspend_ev)
    begin
      st_d.erase_susp = 1'b1;
    end
    if (program_resume_ev)
    begin
      st_d.prog_susp = 1'b0;
    end
    if (program_suspend_ev)
    begin
      st_d.prog_susp = 1'b1;
    end

    // snapshot on access start; held for the rest of the access
    if (async_start)
    begin
      st_d.snap = live;
    end

    // burst sequencer, independent of program or erase being active
    unique case (st_q.bst)
      BST_IDLE:
      begin
        if (burst_start)
        begin
          st_d.snap = live;
          st_d.bst = BST_LAT;
        end
      end
      BST_LAT:
      begin
        if (s_ce_n)
        begin
          st_d.bst = BST_IDLE;
        end
        else if (burst_start)
        begin
          st_d.snap = live;
        end
        else if (lat_done)
        begin
          st_d.bst = BST_STREAM;
        end
      end
      BST_STREAM:
      begin
        if (s_ce_n || !burst_mode)
        begin
          st_d.bst = BST_IDLE;
        end
        else if (burst_start)
        begin
          st_d.snap = live;
          st_d.bst = BST_LAT;
        end
      end
      default:
      begin
        st_d.bst = BST_IDLE;
      end
    endcase

    // drive the bus only with a status access in progress
    st_d.dq_out = {UPPER_FILL, st_d.snap};
    if (!st_q.status_mode)
    begin
      st_d.dq_oe_n = 1'b1;
    end
    else if (burst_mode)
    begin
      st_d.dq_oe_n = ~(access_now && (st_d.bst == BST_STREAM));
    end
    else
    begin
      st_d.dq_oe_n = ~access_now;
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.ce_n_p <= 1'b1;
      st_q.oe_n_p <= 1'b1;
      st_q.avd_n_p <= 1'b1;
      st_q.snap <= SNAP_RESET;
      st_q.bst <= BST_IDLE;
      st_q.dq_out <= DQ_RESET;
      st_q.dq_oe_n <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign dq_out = st_q.dq_out;
  assign dq_oe_n = st_q.dq_oe_n;
  assign status_mode = st_q.status_mode;
  assign op_abort = st_q.op_abort;
  assign write_engine_status_byte = st_q.snap;

  // helper: burst clock edges since the last address latch
  logic [2:0] chk_ticks_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || burst_start)
    begin
      chk_ticks_q <= 3'h0;
    end
    else if (bclk_tick && chk_ticks_q != 3'h7)
    begin
      chk_ticks_q <= chk_ticks_q + 3'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // mode entry and exit
  chk_mode_entry: assert property (
    cmd_wr && cmd_code == CMD_READ_STATUS |=> status_mode)
    else $error("status mode not entered");
  chk_mode_exit: assert property (
    cmd_wr && cmd_code != CMD_READ_STATUS |=> !status_mode ##1 dq_oe_n)
    else $error("status mode not left");

  // upper byte zero while driving
  chk_upper_zero: assert property (
    !dq_oe_n |-> dq_out[DATA_W-1:STAT_W] == UPPER_FILL)
    else $error("upper byte not zero");

  // value stands while the bus stays driven
  chk_snap_hold: assert property (
    !dq_oe_n && $past(!dq_oe_n) |-> $stable(dq_out))
    else $error("status changed during read");

  // ready bit of a fresh snapshot
  chk_ready_bit: assert property (
    async_start |=> write_engine_status_byte[SR_READY] == $past(!engine_busy))
    else $error("ready bit wrong");

  // plane bit of a fresh snapshot
  chk_plane_bit: assert property (
    async_start |=> write_engine_status_byte[SR_PLANE] ==
      $past(engine_busy && busy_plane != plane_of(s_addr)))
    else $error("plane bit wrong");

  // streaming begins only after three clock edges
  chk_burst_lat: assert property (
    $rose(st_q.bst == BST_STREAM) |-> chk_ticks_q == 3'(BURST_LATENCY))
    else $error("burst latency wrong");

  // sequence error sets the four error bits
  chk_seq_error: assert property (
    seq_error_ev |=> st_q.erase_fail && st_q.program_fail && st_q.vpp_low && st_q.locked)
    else $error("sequence error bits missing");

  // errors stay until cleared
  chk_err_sticky: assert property (
    st_q.erase_fail && !clear_cmd |=> st_q.erase_fail)
    else $error("erase failure flag lost");

  // a locked target aborts the operation
  chk_lock_abort: assert property (
    op_start && target_locked |=> st_q.locked && op_abort ##1 !op_abort)
    else $error("locked target not aborted");

  // suspend flags follow suspend, the erase flag also follows resume
  chk_susp_flags: assert property (
    erase_suspend_ev |=> st_q.erase_susp)
    else $error("erase suspend flag not set");
  chk_erase_resume: assert property (
    erase_resume_ev && !erase_suspend_ev |=> !st_q.erase_susp)
    else $error("erase suspend flag not cleared");
  chk_prog_susp: assert property (
    program_suspend_ev |=> st_q.prog_susp)
    else $error("program suspend flag not set");

  cov_async_read: cover property (async_start && status_mode ##1 !dq_oe_n);
  cov_burst_stream: cover property (burst_start ##[1:200] st_q.bst == BST_STREAM);
  cov_seq_error: cover property (seq_error_ev ##1 clear_cmd);

endmodule

/* testbench/fsr_host.sv */
// host controller model: drives select, enable, address-valid, burst clock and address
// assumes its tasks are called just after a rising core_clk edge
`timescale 1ns/100ps
module fsr_host (
  input wire logic core_clk,
  output logic ce_n,
  output logic oe_n,
  output logic addr_valid_n,
  output logic bclk,
  output logic [fsr_pkg::ADDR_W-1:0] addr
);
  logic run;
  initial
  begin
    {ce_n, oe_n, addr_valid_n, bclk, run} = 5'h1c;
    addr = '0;
  end
  // burst clock, 64 ns period, stands still low outside frames
  always
  begin
    #32;
    bclk = run & ~bclk;
  end
  // idle gap: both strobes high, released address shows inverted value
  task automatic idle(input logic [22:0] a);
    run = 1'b0;
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    addr <= ~a;
    repeat (4) @(posedge core_clk);
  endtask
  // asynchronous read, enable falls last and takes the snapshot
  task automatic rd(input logic [22:0] a, input int hold);
    addr <= a;
    ce_n <= 1'b0;
    @(posedge core_clk);
    oe_n <= 1'b0;
    repeat (hold) @(posedge core_clk);
    idle(a);
  endtask
  // burst read: address-valid pulse, enable, clock runs through latency and streaming
  task automatic br(input logic [22:0] a);
    addr <= a;
    ce_n <= 1'b0;
    addr_valid_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    addr_valid_n <= 1'b1;
    oe_n <= 1'b0;
    run = 1'b1;
    repeat (60) @(posedge core_clk);
    idle(a);
  endtask
endmodule

/* testbench/fsr_status_tb.sv */
// self-checking bench for the status register read path
// assumes fsr_host drives the flash pins and this module the engine side
`timescale 1ns/100ps
module fsr_status_tb;
  import fsr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce_n, oe_n, avd_n, bclk, dq_oe_n, status_mode, op_abort;
  logic [22:0] addr;
  logic [15:0] dq_out;
  logic [7:0] sb, cmd_code = 8'h00, fl = 8'h00;
  logic burst_mode = 1'b0, cmd_wr = 1'b0, busy = 1'b0, op_start = 1'b0;
  logic lk = 1'b0, lo = 1'b0, ok;
  logic [4:0] bp = 5'h00;
  logic [6:0] ev = 7'h00;
  logic [7:0] msk [7] = '{8'h20, 8'h10, 8'h3a, 8'h40, 8'h04, 8'h40, 8'h04};
  logic [15:0] exp_q [$];
  logic [15:0] held;
  logic oe_d = 1'b1;
  logic [31:0] seed = 32'hf7d7a014;
  int n_fail = 0;
  int n_checks = 0;
  int t = 0;
  always #4 core_clk = ~core_clk;
  fsr_host u_fsr_host (.core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n),
    .addr_valid_n(avd_n), .bclk(bclk), .addr(addr));
  fsr_status u_fsr_status (.core_clk(core_clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n),
    .addr_valid_n(avd_n), .bclk(bclk), .addr(addr), .program_voltage_low(lo),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .burst_mode(burst_mode), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .engine_busy(busy), .busy_plane(bp), .op_start(op_start),
    .target_locked(lk), .erase_fail_ev(ev[0]), .program_fail_ev(ev[1]),
    .seq_error_ev(ev[2]), .erase_suspend_ev(ev[3]), .program_suspend_ev(ev[4]),
    .erase_resume_ev(ev[5]), .program_resume_ev(ev[6]), .status_mode(status_mode),
    .op_abort(op_abort), .write_engine_status_byte(sb));
  // pseudo-random source
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // expected bus word for a read of address a
  function automatic logic [15:0] expv(input logic [22:0] a);
    logic [7:0] s;
    s = fl;
    s[7] = ~busy;
    s[0] = busy && (a[22:18] != bp);
    return {8'h00, s};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (exp_q.size() != 0)
      n_fail++;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic done;
    t++;
    $display("test %0d finished", t);
  endtask
  // command write, then mode check off the edge
  task automatic cmd(input logic [7:0] c);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check(status_mode, c == CMD_READ_STATUS);
    @(posedge core_clk);
  endtask
  // engine event pulse and model flag update
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev <= 7'h00;
    @(posedge core_clk);
    fl = (i < 5) ? (fl | msk[i]) : (fl & ~msk[i]);
  endtask
  // operation start with lock and supply state, abort expected
  task automatic start(input logic l, input logic v);
    lk <= l;
    lo <= v;
    repeat (4) @(posedge core_clk);
    op_start <= 1'b1;
    @(posedge core_clk);
    op_start <= 1'b0;
    ok = 1'b0;
    repeat (3) @(negedge core_clk) ok |= (op_abort === 1'b1);
    check(ok, 1'b1);
    fl[1] = fl[1] | l;
    fl[3] = fl[3] | v;
    @(posedge core_clk);
    lk <= 1'b0;
    lo <= 1'b0;
    @(posedge core_clk);
  endtask
  // reads take a raw random word; only the word address bits reach the pins
  task automatic ard(input logic [31:0] r, input int hold);
    exp_q.push_back(expv(r[22:0]));
    u_fsr_host.rd(r[22:0], hold);
  endtask
  task automatic bst(input logic [31:0] r);
    exp_q.push_back(expv(r[22:0]));
    u_fsr_host.br(r[22:0]);
  endtask
  // watcher: first driven cycle takes the oldest note, later ones must repeat it
  always @(negedge core_clk)
  begin
    if (dq_oe_n === 1'b0 && oe_d !== 1'b0)
    begin
      held = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
      check(dq_out, held);
    end
    else if (dq_oe_n === 1'b0)
      check(dq_out, held);
    oe_d = dq_oe_n;
  end
  initial
  begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check(sb, SNAP_RESET);
    check(dq_oe_n, 1'b1);
    @(posedge core_clk);
    cmd(CMD_READ_STATUS);
    ard(lfsr(), 6);
    done;
    // addressed plane busy, then another plane busy
    busy <= 1'b1;
    bp <= 5'(lfsr());
    @(posedge core_clk);
    ard({9'h000, bp, 18'(lfsr())}, 6);
    ard({9'h000, bp + 5'h01, 18'(lfsr())}, 6);
    done;
    // event during a held read keeps the old snapshot, next read shows it
    fork
      ard(lfsr(), 24);
      begin
        // event lands well after the snapshot of the held read
        repeat (8) @(posedge core_clk);
        pulse(1);
      end
    join
    ard(lfsr(), 6);
    done;
    // every event in turn with the engine idle
    busy <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      pulse(i);
      ard(lfsr(), 4);
    end
    done;
    // clear earlier errors, then supply low without an operation is not flagged,
    // then locked and low-supply aborts
    cmd(CMD_CLEAR_STATUS);
    fl = fl & 8'h44;
    cmd(CMD_READ_STATUS);
    lo <= 1'b1;
    @(posedge core_clk);
    ard(lfsr(), 4);
    start(1'b1, 1'b0);
    start(1'b0, 1'b1);
    ard(lfsr(), 4);
    cmd(CMD_CLEAR_STATUS);
    fl = fl & 8'h44;
    cmd(CMD_READ_STATUS);
    ard(lfsr(), 4);
    done;
    // burst reads, the first during an erase, the second with the engine idle and a new value
    burst_mode <= 1'b1;
    busy <= 1'b1;
    bp <= 5'(lfsr());
    @(posedge core_clk);
    bst(lfsr());
    busy <= 1'b0;
    @(posedge core_clk);
    bst(lfsr());
    cmd(CMD_READ_ARRAY);
    done;
    complete_run;
  end
endmodule
